// File: rtl/uop_consts.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef UOP_CONSTS_SVH
`define UOP_CONSTS_SVH
// register offsets (byte addresses)
`define UOP_OFS_LINE_CTRL  8'h00
`define UOP_OFS_POWER_CTRL 8'h04
`define UOP_OFS_IRQ_FLAGS  8'h08
`define UOP_OFS_IRQ_EN     8'h0c
`define UOP_OFS_ERR_EN     8'h10
// line control fields
`define UOP_LC_PULLS_HI    7
`define UOP_LC_PULLS_LO    4
`define UOP_LC_VBUS_ON     3
`define UOP_LC_SW_CTRL     2
`define UOP_LC_VBUS_CHG    1
`define UOP_LC_VBUS_DIS    0
// power control fields
`define UOP_PC_ACT_PEND    7
`define UOP_PC_SLEEP_GUARD 4
`define UOP_PC_BUSY        3
`define UOP_PC_SUSPEND     1
`define UOP_PC_MODULE_ON   0
// interrupt flag fields
`define UOP_IF_STALL       7
`define UOP_IF_ATTACH      6
`define UOP_IF_RESUME      5
`define UOP_IF_IDLE        4
`define UOP_IF_TOKEN_DONE  3
`define UOP_IF_FRAME_START 2
`define UOP_IF_ERR_SUM     1
`define UOP_IF_RST_DETACH  0
// reset values
`define UOP_RST_REG8       8'h00
// timing
`define UOP_CLK_PERIOD_NS  10
`define UOP_QUIET_NS       2500
`define UOP_IDLE_MS        3
`define UOP_OFF_DELAY_CYC  8
`endif

// File: rtl/uop_pkg.sv
// types shared by the usb power and interrupt control block
`default_nettype none
package uop_pkg;
  // resistor controls of the two data lines
  typedef struct packed {
    logic dplusPullupEn;
    logic dminusPullupEn;
    logic dplusPulldownEn;
    logic dminusPulldownEn;
  } uop_pull_type;
  // one-cycle events from the usb engine
  typedef struct packed {
    logic stall;
    logic tokenDone;
    logic frameStart;
  } uop_evt_type;
  // decoded line state
  typedef enum logic [1:0] {
    LINE_SE0,
    LINE_J,
    LINE_K,
    LINE_SE1
  } uop_line_type;
endpackage : uop_pkg
`default_nettype wire

// File: rtl/uop_ctrl.sv
// line, power and interrupt status control of a usb otg controller
// Operation
// - bits 7..4 of line control enable the four line pull resistors
// - sw control bit set: software owns pulls; clear: hardware drives them
// - vbus power bit drives the vbus power output
// - vbus charge bit connects the vbus charging pull-up
// - vbus discharge bit connects the vbus discharging pull-down
// - activity pending shows a link event not yet flagged; no sleep then; here pending sets in the same cycle as its flag
// - sleep guard set blocks sleep on bus activity or pending event
// - busy reads 1 while on or disabled but not ready to re-enable
// - suspend gates the 48 MHz usb clock and idles the transceiver
// - module off holds outputs inactive, frees pins, stops analog
// - flags set by hardware, zero after reset; all but error summary cleared by writing 1
// - stall flag set on stall handshake sent or received
// - attach flag set in host mode after 2.5 us quiet, not SE0
// - resume flag set after K state held 2.5 us
// - idle flag set after bus idle for at least 3 ms
// - token done flag set on token end; clearing advances status fifo
// - frame start flag set on received start of frame or host threshold
// - error summary set only by enabled error conditions
// - bit 0 flags bus reset in device mode, detach in host mode
// - bits 31..8 and unimplemented bits read as zero
// - error summary reaches the interrupt only with its enable set
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "uop_consts.svh"

module uop_ctrl
  import uop_pkg::*;
#(
  parameter int ADDR_W   = 8,
  parameter int IDLE_CYC = `UOP_IDLE_MS * 1000000 / `UOP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrStb,
  input  wire logic              regRdStb,
  output logic      [31:0]       regRdData,
  // usb engine side
  input  wire uop_evt_type       engineEvt,
  input  wire uop_pull_type      hwPulls,
  input  wire logic              hostModeEn,
  input  wire logic [7:0]        errPending,
  output logic                   statFifoAdvance,
  // line pins
  input  wire logic              dplusIn,
  input  wire logic              dminusIn,
  // analog and power controls
  output uop_pull_type           linePulls,
  output logic                   vbusPowerOn,
  output logic                   vbusChargeEn,
  output logic                   vbusDischargeEn,
  output logic                   padsOwned,
  output logic                   analogEn,
  output logic                   usbClkEn,
  output logic                   xcvrLowPower,
  output logic                   sleepBlock,
  // interrupt request
  output logic                   moduleIrq
);

  localparam int QUIET_CYC =
    (`UOP_QUIET_NS + `UOP_CLK_PERIOD_NS - 1) / `UOP_CLK_PERIOD_NS;
  localparam int CNT_W = $clog2(IDLE_CYC + 1);
  localparam logic [CNT_W-1:0] QUIET_LAST = CNT_W'(QUIET_CYC - 1);
  localparam logic [CNT_W-1:0] IDLE_LAST  = CNT_W'(IDLE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_MAX    = CNT_W'(IDLE_CYC);
  localparam logic [3:0]       OFF_CYC    = 4'(`UOP_OFF_DELAY_CYC);
  // all checks below run on the core clock, off during reset
  default clocking chkClk @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // software registers
  logic [7:0]       lineCtrl;
  logic             sleepGuard;
  logic             suspendReq;
  logic             moduleOn;
  logic [7:0]       irqFlags;
  logic [7:0]       irqEn;
  logic [7:0]       errorEnableReg;
  logic             activityPending;
  logic [3:0]       offCnt;
  // line sampling
  logic [1:0]       lineS1;
  logic [1:0]       lineS2;
  uop_line_type     lineNow;
  uop_line_type     linePrev;
  logic [CNT_W-1:0] stableCnt;
  logic             wasSe0;
  logic             connected;
  // decoded strobes and events
  logic             wrLine;
  logic             wrPower;
  logic             wrFlags;
  logic             moduleBusy;
  logic [7:0]       next_setEvt;
  logic [7:0]       next_irqFlags;
  logic             quietHit;

  assign wrLine  = regWrStb && regAddr == ADDR_W'(`UOP_OFS_LINE_CTRL);
  assign wrPower = regWrStb && regAddr == ADDR_W'(`UOP_OFS_POWER_CTRL);
  assign wrFlags = regWrStb && regAddr == ADDR_W'(`UOP_OFS_IRQ_FLAGS);
  assign moduleBusy = moduleOn || offCnt != 4'h0;
  assign quietHit   = moduleOn && stableCnt == QUIET_LAST;

  ////////////////////////////////////////////////////////////////////////
  // line control register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lineCtrl <= `UOP_RST_REG8;
    end else if (wrLine) begin
      lineCtrl <= regWrData[7:0];
    end
  end

  // power control register; busy and pending are not writable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sleepGuard <= 1'b0;
      suspendReq <= 1'b0;
      moduleOn   <= 1'b0;
    end else if (wrPower) begin
      sleepGuard <= regWrData[`UOP_PC_SLEEP_GUARD];
      suspendReq <= regWrData[`UOP_PC_SUSPEND];
      moduleOn   <= regWrData[`UOP_PC_MODULE_ON];
    end
  end

  // enable registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqEn          <= `UOP_RST_REG8;
      errorEnableReg <= `UOP_RST_REG8;
    end else if (regWrStb) begin
      if (regAddr == ADDR_W'(`UOP_OFS_IRQ_EN)) begin
        irqEn <= regWrData[7:0];
      end
      if (regAddr == ADDR_W'(`UOP_OFS_ERR_EN)) begin
        errorEnableReg <= regWrData[7:0];
      end
    end
  end

  // shutdown delay after the module is turned off
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      offCnt <= 4'h0;
    end else if (moduleOn) begin
      offCnt <= OFF_CYC;
    end else if (offCnt != 4'h0) begin
      offCnt <= offCnt - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser, reset to idle j so no false change follows
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lineS1 <= 2'h2;
      lineS2 <= 2'h2;
    end else begin
      lineS1 <= {dplusIn, dminusIn};
      lineS2 <= lineS1;
    end
  end

  // full-speed line decode
  always_comb begin
    case (lineS2)
      2'h0:    lineNow = LINE_SE0;
      2'h2:    lineNow = LINE_J;
      2'h1:    lineNow = LINE_K;
      default: lineNow = LINE_SE1;
    endcase
  end

  // time the current line state has been stable, saturating
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      linePrev  <= LINE_J;
      stableCnt <= '0;
    end else begin
      linePrev <= lineNow;
      if (!moduleOn || lineNow != linePrev) begin
        stableCnt <= '0;
      end else if (stableCnt != CNT_MAX) begin
        stableCnt <= stableCnt + CNT_W'(1);
      end
    end
  end

  // connection tracking for attach and detach
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wasSe0    <= 1'b0;
      connected <= 1'b0;
    end else if (!hostModeEn || !moduleOn) begin
      wasSe0    <= 1'b0;
      connected <= 1'b0;
    end else if (quietHit) begin
      wasSe0    <= lineNow == LINE_SE0;
      connected <= lineNow != LINE_SE0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flag set sources
  always_comb begin
    next_setEvt = 8'h00;
    if (moduleOn) begin
      next_setEvt[`UOP_IF_STALL]       = engineEvt.stall;
      next_setEvt[`UOP_IF_TOKEN_DONE]  = engineEvt.tokenDone;
      next_setEvt[`UOP_IF_FRAME_START] = engineEvt.frameStart;
      next_setEvt[`UOP_IF_ATTACH] = hostModeEn && quietHit && wasSe0 &&
                                    lineNow != LINE_SE0;
      next_setEvt[`UOP_IF_RESUME] = quietHit && lineNow == LINE_K;
      next_setEvt[`UOP_IF_IDLE] = lineNow == LINE_J &&
                                  stableCnt == IDLE_LAST;
      // reset in device mode, detach in host mode
      next_setEvt[`UOP_IF_RST_DETACH] = quietHit && lineNow == LINE_SE0 &&
                                        (!hostModeEn || connected);
    end
  end

  // write-one-to-clear flags; a set in the same cycle wins
  always_comb begin
    next_irqFlags = irqFlags;
    if (wrFlags) begin
      next_irqFlags = irqFlags & ~regWrData[7:0];
    end
    next_irqFlags = next_irqFlags | next_setEvt;
    next_irqFlags[`UOP_IF_ERR_SUM] =
      |(errPending & errorEnableReg);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqFlags <= `UOP_RST_REG8;
    end else begin
      irqFlags <= next_irqFlags;
    end
  end

  // pending for the one cycle after a raw event, the same cycle its flag sets
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      activityPending <= 1'b0;
    end else begin
      activityPending <= |next_setEvt;
    end
  end

  // status fifo advance when software clears token done
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      statFifoAdvance <= 1'b0;
    end else begin
      statFifoAdvance <= wrFlags && irqFlags[`UOP_IF_TOKEN_DONE] &&
                         regWrData[`UOP_IF_TOKEN_DONE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pin and power outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      linePulls       <= '0;
      vbusPowerOn     <= 1'b0;
      vbusChargeEn    <= 1'b0;
      vbusDischargeEn <= 1'b0;
      padsOwned       <= 1'b0;
      analogEn        <= 1'b0;
      usbClkEn        <= 1'b0;
      xcvrLowPower    <= 1'b0;
    end else if (!moduleOn) begin
      linePulls       <= '0;
      vbusPowerOn     <= 1'b0;
      vbusChargeEn    <= 1'b0;
      vbusDischargeEn <= 1'b0;
      padsOwned       <= 1'b0;
      analogEn        <= 1'b0;
      usbClkEn        <= 1'b0;
      xcvrLowPower    <= 1'b0;
    end else begin
      if (lineCtrl[`UOP_LC_SW_CTRL]) begin
        linePulls <= lineCtrl[`UOP_LC_PULLS_HI:`UOP_LC_PULLS_LO];
      end else begin
        linePulls <= hwPulls;
      end
      vbusPowerOn     <= lineCtrl[`UOP_LC_VBUS_ON];
      vbusChargeEn    <= lineCtrl[`UOP_LC_VBUS_CHG];
      vbusDischargeEn <= lineCtrl[`UOP_LC_VBUS_DIS];
      padsOwned       <= 1'b1;
      analogEn        <= 1'b1;
      usbClkEn        <= !suspendReq;
      xcvrLowPower    <= suspendReq;
    end
  end

  // sleep guard and interrupt request
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sleepBlock <= 1'b0;
      moduleIrq  <= 1'b0;
    end else begin
      sleepBlock <= sleepGuard && (activityPending ||
                    (moduleOn && lineNow != LINE_J));
      moduleIrq  <= |(next_irqFlags & irqEn);
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 32'h0000_0000;
    end else begin
      regRdData <= 32'h0000_0000;
      if (regRdStb) begin
        case (regAddr)
          ADDR_W'(`UOP_OFS_LINE_CTRL):  regRdData[7:0] <= lineCtrl;
          ADDR_W'(`UOP_OFS_POWER_CTRL): regRdData[7:0] <=
            {activityPending, 2'h0, sleepGuard, moduleBusy, 1'b0,
             suspendReq, moduleOn};
          ADDR_W'(`UOP_OFS_IRQ_FLAGS):  regRdData[7:0] <= irqFlags;
          ADDR_W'(`UOP_OFS_IRQ_EN):     regRdData[7:0] <= irqEn;
          ADDR_W'(`UOP_OFS_ERR_EN):     regRdData[7:0] <= errorEnableReg;
          default:                      regRdData <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  flag_w1c_a: assert property (
    wrFlags && regWrData[`UOP_IF_STALL] && !next_setEvt[`UOP_IF_STALL]
    |=> !irqFlags[`UOP_IF_STALL])
    else $error("stall flag not cleared by write one");
  flag_keep_a: assert property (
    irqFlags[`UOP_IF_IDLE] && !(wrFlags && regWrData[`UOP_IF_IDLE])
    |=> irqFlags[`UOP_IF_IDLE])
    else $error("idle flag lost without a clear");
  pull_sw_a: assert property (
    moduleOn && lineCtrl[`UOP_LC_SW_CTRL] |=>
    linePulls == $past(lineCtrl[7:4]))
    else $error("pull outputs do not follow software bits");
  off_quiet_a: assert property (
    !moduleOn |=> !vbusPowerOn && !padsOwned && linePulls == '0)
    else $error("outputs active while module off");
  busy_hold_a: assert property (
    $fell(moduleOn) |-> moduleBusy [*8] ##1 !moduleBusy)
    else $error("busy does not span the shutdown delay");
  resume_time_a: assert property (
    $rose(irqFlags[`UOP_IF_RESUME]) |-> $past(stableCnt) == QUIET_LAST)
    else $error("resume flagged at wrong time");
  irq_gate_a: assert property (irqEn == 8'h00 |=> !moduleIrq)
    else $error("interrupt with all enables clear");
  err_mask_a: assert property (
    errorEnableReg == 8'h00 |=> !irqFlags[`UOP_IF_ERR_SUM])
    else $error("masked error set summary");
  suspend_clk_a: assert property (suspendReq |=> !usbClkEn)
    else $error("usb clock runs in suspend");

endmodule : uop_ctrl
`default_nettype wire

// File: bench/uop_bus_peer.sv
// usb bus peer model driving the data line pair to a commanded state
`timescale 1ns/1ns
`default_nettype none

module uop_bus_peer
  import uop_pkg::*;
(
  // commanded bus state
  input  wire uop_line_type lineCmd,
  // line pair towards the block
  output logic              dplus,
  output logic              dminus
);
  ////////////////////////////////////////////////////////////////////////
  // j drives d+ high, k drives d- high, se0 holds both low
  always_comb begin
    case (lineCmd)
      LINE_J:  {dplus, dminus} = 2'b10;
      LINE_K:  {dplus, dminus} = 2'b01;
      LINE_SE1: {dplus, dminus} = 2'b11;
      default: {dplus, dminus} = 2'b00;
    endcase
  end
endmodule : uop_bus_peer

`default_nettype wire

// File: bench/uop_ctrl_tb.sv
// self-checking bench of the usb power and interrupt control block
`timescale 1ns/1ns
`default_nettype none
`include "uop_consts.svh"

module uop_ctrl_tb;
  import uop_pkg::*;
  localparam int         IDLE = 600;
  localparam logic [7:0] LC   = `UOP_OFS_LINE_CTRL;
  localparam logic [7:0] PC   = `UOP_OFS_POWER_CTRL;
  localparam logic [7:0] IFR  = `UOP_OFS_IRQ_FLAGS;
  localparam logic [7:0] IE   = `UOP_OFS_IRQ_EN;
  localparam logic [7:0] EE   = `UOP_OFS_ERR_EN;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic         core_clk, rst_b, regWrStb, regRdStb, hostModeEn;
  logic [7:0]   regAddr, errPending;
  logic [31:0]  regWrData, regRdData;
  uop_evt_type  engineEvt;
  uop_pull_type hwPulls, linePulls;
  uop_line_type lineCmd;
  logic         dplus, dminus, statFifoAdvance, sleepBlock, moduleIrq;
  logic         vbusPowerOn, vbusChargeEn, vbusDischargeEn;
  logic         padsOwned, analogEn, usbClkEn, xcvrLowPower, blk;
  logic [10:0]  outs;
  int           miscompares, samplesChecked, cycles;

  assign outs = {linePulls, vbusPowerOn, vbusChargeEn, vbusDischargeEn,
                 padsOwned, analogEn, usbClkEn, xcvrLowPower};

  ////////////////////////////////////////////////////////////////////////
  uop_ctrl #(.ADDR_W(8), .IDLE_CYC(IDLE)) u_uop_ctrl (
    .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .engineEvt(engineEvt), .hwPulls(hwPulls),
    .hostModeEn(hostModeEn), .errPending(errPending),
    .statFifoAdvance(statFifoAdvance), .dplusIn(dplus), .dminusIn(dminus),
    .linePulls(linePulls), .vbusPowerOn(vbusPowerOn),
    .vbusChargeEn(vbusChargeEn), .vbusDischargeEn(vbusDischargeEn),
    .padsOwned(padsOwned), .analogEn(analogEn), .usbClkEn(usbClkEn),
    .xcvrLowPower(xcvrLowPower), .sleepBlock(sleepBlock),
    .moduleIrq(moduleIrq));

  uop_bus_peer u_uop_bus_peer (
    .lineCmd(lineCmd), .dplus(dplus), .dminus(dminus));

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      $display("[FAIL] %0t run did not finish", $time);
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge core_clk);
    regWrStb  <= 1'b0;
  endtask : wr
  // one-cycle read strobe, data taken in the following cycle
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    @(posedge core_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1;
    chk(regRdData & m, e);
  endtask : rchk
  task automatic ev(input logic [2:0] e);
    @(posedge core_clk);
    engineEvt <= uop_evt_type'(e);
    @(posedge core_clk);
    engineEvt <= uop_evt_type'(3'h0);
  endtask : ev
  // hold a bus state, then look at the flags under a mask
  task automatic line(input uop_line_type s, input int n,
                      input logic [31:0] m, input logic [31:0] e);
    lineCmd <= s;
    cyc(n);
    rchk(IFR, m, e);
  endtask : line
  task automatic close_out;
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {regAddr, regWrData, regWrStb, regRdStb, errPending} = '0;
    {hostModeEn, miscompares, samplesChecked, cycles} = '0;
    engineEvt = uop_evt_type'(3'h0);
    hwPulls   = uop_pull_type'(4'ha);
    lineCmd   = LINE_J;
    rst_b     = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) rchk(8'(i * 4), ALL, 32'h0);
    chk(32'(outs), 32'h0);
    wr(PC, 32'h1);
    rchk(PC, ALL, 32'h09);
    cyc(2);
    chk(32'(outs), 32'(11'b1010_000_1110));
    wr(LC, ALL - 32'h3);
    cyc(2);
    chk(32'(outs), 32'(11'b1111_100_1110));
    rchk(LC, ALL, 32'hfc);
    wr(LC, 32'h53);
    cyc(2);
    chk(32'(outs), 32'(11'b1010_011_1110));
    wr(LC, 32'h54);
    cyc(2);
    chk(32'(outs), 32'(11'b0101_000_1110));
    // stall flagged but kept off the interrupt, only token done enabled
    wr(IE, 32'h08);
    ev(3'h4);
    cyc(2);
    chk(32'(moduleIrq), 32'h0);
    wr(IFR, 32'h0);
    rchk(IFR, ALL, 32'h80);
    wr(IFR, 32'h80);
    rchk(IFR, ALL, 32'h0);
    ev(3'h2);
    cyc(2);
    chk(32'(moduleIrq), 32'h1);
    rchk(IFR, ALL, 32'h08);
    wr(IFR, 32'h08);
    #1;
    chk(32'(statFifoAdvance), 32'h1);
    cyc(1);
    chk(32'(statFifoAdvance), 32'h0);
    cyc(2);
    chk(32'(moduleIrq), 32'h0);
    ev(3'h1);
    rchk(IFR, ALL, 32'h04);
    wr(IFR, 32'h04);
    // error summary only through its enables
    errPending <= 8'h04;
    cyc(3);
    rchk(IFR, ALL, 32'h0);
    wr(EE, 32'h04);
    cyc(2);
    rchk(IFR, ALL, 32'h02);
    chk(32'(moduleIrq), 32'h0);
    wr(IE, 32'h0a);
    cyc(2);
    chk(32'(moduleIrq), 32'h1);
    errPending <= 8'h00;
    cyc(3);
    rchk(IFR, ALL, 32'h0);
    // sleep guard against a pending event, then against bus activity
    wr(PC, 32'h11);
    cyc(2);
    chk(32'(sleepBlock), 32'h0);
    ev(3'h1);
    blk = 1'b0;
    repeat (4) begin
      @(posedge core_clk);
      #1 blk |= sleepBlock;
    end
    chk(32'(blk), 32'h1);
    wr(IFR, 32'h04);
    line(LINE_K, 200, 32'h20, 32'h0);
    chk(32'(sleepBlock), 32'h1);
    line(LINE_K, 100, 32'h20, 32'h20);
    wr(PC, 32'h1);
    cyc(2);
    chk(32'(sleepBlock), 32'h0);
    line(LINE_SE0, 300, 32'h01, 32'h01);
    wr(IFR, ALL);
    line(LINE_J, 400, 32'h10, 32'h0);
    line(LINE_J, 300, 32'h10, 32'h10);
    hostModeEn <= 1'b1;
    line(LINE_SE0, 300, 32'h41, 32'h0);
    wr(IFR, ALL);
    line(LINE_J, 300, 32'h41, 32'h40);
    line(LINE_SE0, 300, 32'h01, 32'h01);
    // suspend, then switch off and wait out busy
    wr(PC, 32'h3);
    cyc(2);
    chk(32'(outs), 32'(11'b0101_000_1101));
    rchk(PC, ALL, 32'h0b);
    wr(PC, 32'h0);
    cyc(2);
    chk(32'(outs), 32'h0);
    rchk(PC, 32'h08, 32'h08);
    cyc(12);
    // busy has dropped by now; power control reads zero
    rchk(PC, ALL, 32'h0);
    close_out();
  end
endmodule : uop_ctrl_tb

`default_nettype wire
